// ### rtl/oepd_defines.svh
/*
 * Offsets, field positions and reset values of the out endpoint
 * descriptor block.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef OEPD_DEFINES_SVH
`define OEPD_DEFINES_SVH

// ----------------------------------------
// Register offsets within the block
// ----------------------------------------
`define OEPD_CONFIG_OFS 4'h0
`define OEPD_X_BASE_OFS 4'h1
`define OEPD_LENGTH_OFS 4'h2
`define OEPD_X_COUNT_OFS 4'h3
`define OEPD_Y_BASE_OFS 4'h5
`define OEPD_Y_COUNT_OFS 4'h7
`define OEPD_IRQ_STATUS_OFS 4'h8
`define OEPD_IRQ_MASK_OFS 4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OEPD_CFG_ENABLE_BIT 7
`define OEPD_CFG_ISO_BIT 6
`define OEPD_CFG_DOUBLE_BIT 4
`define OEPD_HELD_BIT 7
`define OEPD_IRQ_X_BIT 0
`define OEPD_IRQ_Y_BIT 1
`define OEPD_IRQ_NAK_BIT 2
`define OEPD_LOW_ZERO_BITS 3'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OEPD_BYTE_RESET 8'h00
`define OEPD_IRQ_RESET 3'h0

`endif

// ### rtl/oepd_out_endpoint.sv
/*
 * One out endpoint descriptor: buffer bases, shared length, X/Y counts
 * with packet-held flags, handshake decision, interrupt status and mask.
 * Assumes a same-clock transaction engine and a simple register port.
 */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "oepd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module oepd_out_endpoint
    import oepd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire oepd_txn_type txn,
    output oepd_reply_type reply,
    output logic irq
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // samples from bytes
    // When isochronous, bytes per sample is config bits 1:0 plus one
    function automatic logic [6:0] count_of(input logic [7:0] bytes, input logic iso, input logic [1:0] bps);
        logic [7:0] q;
        q = bytes;
        if (iso) begin
            case (bps)
                2'h1: q = bytes >> 1;
                2'h2: q = bytes / 8'h03;
                2'h3: q = bytes >> 2;
                default: q = bytes;
            endcase
        end
        return q[6:0];
    endfunction : count_of

    function automatic logic [10:0] align8(input logic [7:0] upper);
        return {upper, `OEPD_LOW_ZERO_BITS};
    endfunction : align8

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] config_byte;
    logic [7:0] out_ep_x_buffer_base;
    logic [7:0] out_ep_y_buffer_base;
    logic [7:0] out_ep_buffer_length;
    logic [7:0] out_ep_x_count_and_hold;
    logic [7:0] out_ep_y_count_and_hold;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    oepd_state_type state;
    logic use_y;
    logic rx_y;

    logic iso;
    logic enabled;
    logic double_buf;
    logic target_y;
    logic target_held;
    logic landed;
    logic nak_now;
    logic [6:0] new_count;

    assign iso = config_byte[`OEPD_CFG_ISO_BIT];
    assign enabled = config_byte[`OEPD_CFG_ENABLE_BIT];
    assign double_buf = config_byte[`OEPD_CFG_DOUBLE_BIT];
    assign target_y = double_buf & use_y;
    assign target_held = target_y ? out_ep_y_count_and_hold[`OEPD_HELD_BIT]
                                  : out_ep_x_count_and_hold[`OEPD_HELD_BIT];
    assign landed = (state == OEPD_RECV) && txn.done && txn.good;
    assign new_count = count_of(txn.bytes, iso, config_byte[1:0]);

    // NAK on held buffer, never when isochronous
    assign nak_now = (state == OEPD_IDLE) && txn.token && enabled && !iso && target_held;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            config_byte <= `OEPD_BYTE_RESET;
            out_ep_x_buffer_base <= `OEPD_BYTE_RESET;
            out_ep_y_buffer_base <= `OEPD_BYTE_RESET;
            out_ep_buffer_length <= `OEPD_BYTE_RESET;
            irq_mask <= `OEPD_IRQ_RESET;
        end else if (reg_write) begin
            if (reg_addr == `OEPD_CONFIG_OFS) begin
                config_byte <= reg_wdata;
            end else if (reg_addr == `OEPD_X_BASE_OFS) begin
                out_ep_x_buffer_base <= reg_wdata;
            end else if (reg_addr == `OEPD_Y_BASE_OFS) begin
                out_ep_y_buffer_base <= reg_wdata;
            end else if (reg_addr == `OEPD_LENGTH_OFS) begin
                out_ep_buffer_length <= reg_wdata;
            end else if (reg_addr == `OEPD_IRQ_MASK_OFS) begin
                irq_mask <= reg_wdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Count and held bytes
    // ----------------------------------------
    // Hardware landing wins over a software write in the same cycle
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            out_ep_x_count_and_hold <= `OEPD_BYTE_RESET;
        end else if (landed && !rx_y) begin
            out_ep_x_count_and_hold <= {1'b1, new_count};
        end else if (reg_write && reg_addr == `OEPD_X_COUNT_OFS) begin
            out_ep_x_count_and_hold <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            out_ep_y_count_and_hold <= `OEPD_BYTE_RESET;
        end else if (landed && rx_y) begin
            out_ep_y_count_and_hold <= {1'b1, new_count};
        end else if (reg_write && reg_addr == `OEPD_Y_COUNT_OFS) begin
            out_ep_y_count_and_hold <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Transaction handling
    // ----------------------------------------
    // A token during reception is dropped; the engine owns one packet at a time
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= OEPD_IDLE;
            rx_y <= 1'b0;
            use_y <= 1'b0;
        end else begin
            case (state)
                OEPD_IDLE: begin
                    if (txn.token && enabled && !nak_now) begin
                        state <= OEPD_RECV;
                        rx_y <= target_y;
                    end
                end
                OEPD_RECV: begin
                    if (txn.done) begin
                        state <= OEPD_IDLE;
                        if (txn.good && double_buf) begin
                            use_y <= !rx_y;
                        end
                    end
                end
                default: begin
                    state <= OEPD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            reply <= '0;
        end else begin
            reply.nak <= nak_now;
            reply.ack <= (state == OEPD_IDLE) && txn.token && enabled && !nak_now;
            reply.base <= align8(target_y ? out_ep_y_buffer_base : out_ep_x_buffer_base);
            reply.limit <= align8(out_ep_buffer_length);
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Set wins over a write-one clear
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            irq_status <= `OEPD_IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~((reg_write && reg_addr == `OEPD_IRQ_STATUS_OFS) ? reg_wdata[2:0] : 3'h0))
                        | {nak_now, landed && rx_y, landed && !rx_y};
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    logic [7:0] next_reg_rdata;

    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_addr == `OEPD_CONFIG_OFS) begin
            next_reg_rdata = config_byte;
        end else if (reg_addr == `OEPD_X_BASE_OFS) begin
            next_reg_rdata = out_ep_x_buffer_base;
        end else if (reg_addr == `OEPD_LENGTH_OFS) begin
            next_reg_rdata = out_ep_buffer_length;
        end else if (reg_addr == `OEPD_X_COUNT_OFS) begin
            next_reg_rdata = out_ep_x_count_and_hold;
        end else if (reg_addr == `OEPD_Y_BASE_OFS) begin
            next_reg_rdata = out_ep_y_buffer_base;
        end else if (reg_addr == `OEPD_Y_COUNT_OFS) begin
            next_reg_rdata = out_ep_y_count_and_hold;
        end else if (reg_addr == `OEPD_IRQ_STATUS_OFS) begin
            next_reg_rdata = {5'h00, irq_status};
        end else if (reg_addr == `OEPD_IRQ_MASK_OFS) begin
            next_reg_rdata = {5'h00, irq_mask};
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? next_reg_rdata : 8'h00;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    y_base_place_a: assert property (@(posedge clk) disable iff (!rst_sync)
        reply.ack && rx_y |-> reply.base[10:3] == $past(out_ep_y_buffer_base))
        else $error("Y base not placed");
    x_base_place_a: assert property (@(posedge clk) disable iff (!rst_sync)
        reply.ack && !rx_y |-> reply.base[10:3] == $past(out_ep_x_buffer_base))
        else $error("X base not placed");
    base_align_a: assert property (@(posedge clk) disable iff (!rst_sync)
        reply.ack |-> reply.base[2:0] == 3'h0)
        else $error("Base not on 8-byte bound");
    x_held_set_a: assert property (@(posedge clk) disable iff (!rst_sync)
        landed && !rx_y |=> out_ep_x_count_and_hold[7] && irq_status[0])
        else $error("X held flag not set");
    nak_held_a: assert property (@(posedge clk) disable iff (!rst_sync)
        state == OEPD_IDLE && txn.token && enabled && !iso && target_held |=> reply.nak && !reply.ack)
        else $error("Held buffer not refused");
    iso_no_nak_a: assert property (@(posedge clk) disable iff (!rst_sync)
        state == OEPD_IDLE && txn.token && enabled && iso |=> reply.ack && !reply.nak)
        else $error("Isochronous token refused");
    x_count_load_a: assert property (@(posedge clk) disable iff (!rst_sync)
        landed && !rx_y && !iso |=> out_ep_x_count_and_hold[6:0] == $past(txn.bytes[6:0]))
        else $error("X byte count wrong");
    iso_samples_a: assert property (@(posedge clk) disable iff (!rst_sync)
        landed && iso && config_byte[1:0] == 2'h3 |=> (rx_y ? out_ep_y_count_and_hold[6:0]
            : out_ep_x_count_and_hold[6:0]) == 7'($past(txn.bytes) >> 2))
        else $error("Sample count wrong");
    length_units_a: assert property (@(posedge clk) disable iff (!rst_sync)
        reply.ack |-> reply.limit == {$past(out_ep_buffer_length), 3'h0})
        else $error("Length not in 8-byte units");
    y_held_set_a: assert property (@(posedge clk) disable iff (!rst_sync)
        landed && rx_y |=> out_ep_y_count_and_hold[7] && out_ep_y_count_and_hold[6:0] == $past(new_count))
        else $error("Y held flag not set");

endmodule : oepd_out_endpoint
`default_nettype wire

// ### rtl/oepd_pkg.sv
/*
 * Types shared by the out endpoint descriptor block.
 * Assumes the transaction engine runs on the same clock as the block.
 */
package oepd_pkg;

    // Events from the USB transaction engine
    typedef struct packed {
        logic token;
        logic done;
        logic good;
        logic [7:0] bytes;
    } oepd_txn_type;

    // Answer to the transaction engine and buffer writer
    typedef struct packed {
        logic ack;
        logic nak;
        logic [10:0] base;
        logic [10:0] limit;
    } oepd_reply_type;

    typedef enum logic [1:0] {
        OEPD_IDLE = 2'b01,
        OEPD_RECV = 2'b10
    } oepd_state_type;

endpackage : oepd_pkg

// ### verification/oepd_host_model.sv
/*
 * USB host model issuing out transactions to one endpoint.
 * Assumes the endpoint answers one cycle after the token.
 */
`timescale 1ns/1ps
`default_nettype none

module oepd_host_model
    import oepd_pkg::*;
(
    input wire logic clk,
    input wire oepd_reply_type reply,
    output var oepd_txn_type txn
);
    // ----------------
    // Out transaction
    // ----------------
    initial txn = '0;

    // Gap stretches the data stage, as a slow host would
    task automatic send(input logic [7:0] n, input logic ok, input int gap,
        output logic [1:0] ans, output logic [10:0] b, output logic [10:0] l);
        @(posedge clk);
        txn.token <= 1'b1;
        @(posedge clk);
        txn.token <= 1'b0;
        @(posedge clk);
        ans = {reply.ack, reply.nak};
        b = reply.base;
        l = reply.limit;
        if (ans == 2'b10) begin
            repeat (gap) @(posedge clk);
            txn.done <= 1'b1;
            txn.good <= ok;
            txn.bytes <= n;
            @(posedge clk);
            txn.done <= 1'b0;
            // Released lines show garbage, never the last packet
            txn.good <= ~ok;
            txn.bytes <= ~n;
        end
    endtask : send
endmodule : oepd_host_model

`default_nettype wire

// ### verification/oepd_out_endpoint_tb_top.sv
/*
 * Self-checking bench for one out endpoint descriptor.
 * Assumes the host model answers for the USB side.
 */
`timescale 1ns/1ps
`default_nettype none

module oepd_out_endpoint_tb_top
    import oepd_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [3:0] ra;
    logic [7:0] wd;
    logic we;
    logic re;
    logic [7:0] rd;
    logic irq;
    oepd_txn_type txn;
    oepd_reply_type reply;
    logic [1:0] ans;
    logic [10:0] b;
    logic [10:0] l;
    int errors;
    int checked;
    int cycles = 0;

    oepd_out_endpoint dut (.clk(clk), .rst_n(rst_n), .reg_addr(ra), .reg_wdata(wd), .reg_write(we),
        .reg_read(re), .reg_rdata(rd), .txn(txn), .reply(reply), .irq(irq));
    oepd_host_model host (.clk(clk), .reply(reply), .txn(txn));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        wd <= ~d;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        re <= 1'b1;
        ra <= a;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        chk(what, {3'h0, rd}, {3'h0, exp});
    endtask : rchk

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end

    // ----------------
    // Tests
    // ----------------
    initial begin
        rst_n = 1'b0;
        ra = 4'h0;
        wd = 8'h00;
        we = 1'b0;
        re = 1'b0;
        errors = 0;
        checked = 0;
        do_reset();
        for (int i = 0; i < 10; i++) begin
            rchk("reset", 4'(i), 8'h00);
        end
        wr(4'h4, 8'hFF);
        rchk("unmapped", 4'h4, 8'h00);
        host.send(8'h05, 1'b1, 0, ans, b, l);
        chk("disabled", {9'h0, ans}, 11'h000);
        $display("test reset done");
        wr(4'h1, 8'hA5);
        wr(4'h5, 8'h3C);
        wr(4'h2, 8'h18);
        rchk("ybase", 4'h5, 8'h3C);
        rchk("len", 4'h2, 8'h18);
        wr(4'h0, 8'h80);
        host.send(8'h45, 1'b1, 0, ans, b, l);
        chk("ack", {9'h0, ans}, 11'h002);
        chk("xbase", b, {8'hA5, 3'h0});
        chk("limit", l, 11'h0C0);
        rchk("xcnt", 4'h3, 8'hC5);
        rchk("stat", 4'h8, 8'h01);
        chk("irq off", {10'h0, irq}, 11'h000);
        wr(4'h9, 8'h05);
        rchk("mask", 4'h9, 8'h05);
        chk("irq on", {10'h0, irq}, 11'h001);
        host.send(8'h10, 1'b1, 0, ans, b, l);
        chk("nak", {9'h0, ans}, 11'h001);
        rchk("stat nak", 4'h8, 8'h05);
        wr(4'h3, 8'h00);
        wr(4'h8, 8'h07);
        rchk("stat clr", 4'h8, 8'h00);
        chk("irq clr", {10'h0, irq}, 11'h000);
        host.send(8'h7F, 1'b1, 2, ans, b, l);
        chk("ack slow", {9'h0, ans}, 11'h002);
        rchk("xcnt max", 4'h3, 8'hFF);
        wr(4'h3, 8'h00);
        wr(4'h8, 8'h07);
        host.send(8'h22, 1'b0, 0, ans, b, l);
        rchk("bad cnt", 4'h3, 8'h00);
        rchk("bad stat", 4'h8, 8'h00);
        $display("test single buffer done");
        do_reset();
        rchk("xbase rst", 4'h1, 8'h00);
        wr(4'h1, 8'h10);
        wr(4'h5, 8'h3F);
        wr(4'h2, 8'h01);
        wr(4'h0, 8'h90);
        host.send(8'h08, 1'b1, 0, ans, b, l);
        chk("x first", b, {8'h10, 3'h0});
        chk("limit 8", l, 11'h008);
        host.send(8'h03, 1'b1, 1, ans, b, l);
        chk("y ack", {9'h0, ans}, 11'h002);
        chk("y base", b, {8'h3F, 3'h0});
        rchk("ycnt", 4'h7, 8'h83);
        rchk("stat xy", 4'h8, 8'h03);
        host.send(8'h01, 1'b1, 0, ans, b, l);
        chk("x held", {9'h0, ans}, 11'h001);
        $display("test double buffer done");
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, 8'hC0 | 8'(k));
            host.send(8'h61, 1'b1, k, ans, b, l);
            chk("iso ack", {9'h0, ans}, 11'h002);
            rchk("iso cnt", 4'h3, 8'h80 | 8'(97 / (k + 1)));
        end
        wr(4'h3, 8'h18);
        rchk("iso clr", 4'h3, 8'h18);
        $display("test isochronous done");
        test_done();
    end
endmodule : oepd_out_endpoint_tb_top

`default_nettype wire
